// ### design/icu_defs.svh
// Constants for the input capture unit
`ifndef ICU_DEFS_SVH
`define ICU_DEFS_SVH
`define ICU_ADDR_CTRL 12'h000
`define ICU_ADDR_CAPLO 12'h004
`define ICU_ADDR_CAPHI 12'h008
`define ICU_ADDR_STAT 12'h00C
`define ICU_ADDR_MASK 12'h010
`define ICU_ADDR_TSEL 12'h014
`define ICU_ADDR_PIN 12'h018
`define ICU_MODE_OFF 4'h0
`define ICU_MODE_FALL 4'h4
`define ICU_MODE_RISE 4'h5
`define ICU_MODE_RISE4 4'h6
`define ICU_MODE_RISE16 4'h7
`define ICU_DIV4_LAST 4'h3
`define ICU_DIV16_LAST 4'hF
`define ICU_CTRL_RST 4'h0
`define ICU_PS_ZERO 4'h0
`define ICU_CNT_ZERO 16'h0000
`define ICU_WORD_ZERO 32'h0000_0000
`endif

// ### design/icu_pkg.sv
// Types for the input capture unit
package icu_pkg;
  typedef logic [3:0] icu_mode_t;
  typedef logic [15:0] icu_count_t;
  typedef enum logic [1:0] {ICU_IDLE = 2'b00, ICU_SETUP = 2'b01, ICU_ACCESS = 2'b11} icu_apb_e;
endpackage

// ### design/icu_sync.sv
// Two-stage synchroniser for the capture pin
`timescale 1ns/1ps
`default_nettype none
module icu_sync (
  input wire logic clock,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### design/input_capture_unit.sv
// Input capture channel with APB register access
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "icu_defs.svh"
module input_capture_unit (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic captureInputPinIn,
  output logic captureInputPinOut,
  output logic captureInputPinOe_n,
  input wire icu_pkg::icu_count_t firstTimerCount,
  input wire icu_pkg::icu_count_t thirdTimerCount,
  input wire logic firstTimerAsync,
  input wire logic thirdTimerAsync,
  output logic irq
);
  import icu_pkg::*;

  icu_mode_t captureModeField_r;
  icu_count_t captureValue_r;
  logic captureIrqFlag_r;
  logic captureIrqEnable_r;
  logic thirdTimerControl_r;
  logic pinDirectionBit_r;
  logic pinLatch_r;
  logic [3:0] psCount_r;
  logic pinSync;
  logic pinPrev_r;
  logic rawRise;
  logic rawFall;
  logic captureEvent;
  logic psHit;
  logic writeAccess;
  logic readAccess;
  logic selAsync;
  icu_count_t selCount;
  icu_apb_e apbState_r;

  function automatic logic isCaptureMode(input icu_mode_t m);
    isCaptureMode = (m == `ICU_MODE_FALL) || (m == `ICU_MODE_RISE) ||
                    (m == `ICU_MODE_RISE4) || (m == `ICU_MODE_RISE16);
  endfunction

  function automatic logic isDivMode(input icu_mode_t m);
    isDivMode = (m == `ICU_MODE_RISE4) || (m == `ICU_MODE_RISE16);
  endfunction

  function automatic logic hitAddr(input logic [11:0] a, input logic [11:0] target);
    hitAddr = (a == target);
  endfunction

  // Pin buffer drives from latch when direction bit is 0 (output)
  always_ff @(posedge clock) begin
    if (srst) begin
      captureInputPinOut <= 1'b0;
      captureInputPinOe_n <= 1'b1;
    end else begin
      captureInputPinOut <= pinLatch_r;
      captureInputPinOe_n <= pinDirectionBit_r;
    end
  end

  // The pad level is sampled regardless of direction, so a port write can capture
  icu_sync uSync (
    .clock(clock),
    .srst(srst),
    .din(captureInputPinIn),
    .dout(pinSync)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      pinPrev_r <= 1'b0;
    end else begin
      pinPrev_r <= pinSync;
    end
  end

  assign rawRise = pinSync & ~pinPrev_r;
  assign rawFall = ~pinSync & pinPrev_r;

  // timer choice; async counter mode gives no capture
  assign selCount = thirdTimerControl_r ? thirdTimerCount : firstTimerCount;
  assign selAsync = thirdTimerControl_r ? thirdTimerAsync : firstTimerAsync;

  assign psHit = (captureModeField_r == `ICU_MODE_RISE4) ? (psCount_r == `ICU_DIV4_LAST)
                                                          : (psCount_r == `ICU_DIV16_LAST);

  always_comb begin
    captureEvent = 1'b0;
    if (!selAsync) begin
      unique case (captureModeField_r)
        `ICU_MODE_FALL: captureEvent = rawFall;
        `ICU_MODE_RISE: captureEvent = rawRise;
        `ICU_MODE_RISE4, `ICU_MODE_RISE16: captureEvent = rawRise & psHit;
        default: captureEvent = 1'b0;
      endcase
    end
  end

  // Prescaler is not cleared when switching between divided modes
  always_ff @(posedge clock) begin
    if (srst) begin
      psCount_r <= `ICU_PS_ZERO;
    end else if (!isCaptureMode(captureModeField_r)) begin
      psCount_r <= `ICU_PS_ZERO;
    end else if (isDivMode(captureModeField_r) && rawRise && !selAsync) begin
      psCount_r <= psHit ? `ICU_PS_ZERO : psCount_r + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      captureValue_r <= `ICU_CNT_ZERO;
    end else if (captureEvent) begin
      captureValue_r <= selCount;
    end
  end

  // APB: no wait states, pready high in the first access cycle after setup
  assign writeAccess = psel & penable & pwrite & pready;
  assign readAccess = psel & ~penable & ~pwrite;

  always_ff @(posedge clock) begin
    if (srst) begin
      apbState_r <= ICU_IDLE;
      pready <= 1'b0;
    end else begin
      unique case (apbState_r)
        ICU_IDLE: begin
          pready <= 1'b0;
          if (psel && !penable) begin
            apbState_r <= ICU_SETUP;
            pready <= 1'b1;
          end
        end
        ICU_SETUP: begin
          apbState_r <= ICU_ACCESS;
          pready <= 1'b0;
        end
        ICU_ACCESS: begin
          apbState_r <= ICU_IDLE;
          pready <= 1'b0;
          if (psel && !penable) begin
            apbState_r <= ICU_SETUP;
            pready <= 1'b1;
          end
        end
        default: begin
          apbState_r <= ICU_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      captureModeField_r <= `ICU_CTRL_RST;
      captureIrqEnable_r <= 1'b0;
      thirdTimerControl_r <= 1'b0;
      pinDirectionBit_r <= 1'b1;
      pinLatch_r <= 1'b0;
    end else if (writeAccess) begin
      if (hitAddr(paddr, `ICU_ADDR_CTRL)) begin
        captureModeField_r <= pwdata[3:0];
      end
      if (hitAddr(paddr, `ICU_ADDR_MASK)) begin
        captureIrqEnable_r <= pwdata[0];
      end
      if (hitAddr(paddr, `ICU_ADDR_TSEL)) begin
        thirdTimerControl_r <= pwdata[0];
      end
      if (hitAddr(paddr, `ICU_ADDR_PIN)) begin
        pinLatch_r <= pwdata[0];
        pinDirectionBit_r <= pwdata[1];
      end
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      captureIrqFlag_r <= 1'b0;
    end else if (captureEvent) begin
      captureIrqFlag_r <= 1'b1;
    end else if (writeAccess && hitAddr(paddr, `ICU_ADDR_STAT) && pwdata[0]) begin
      captureIrqFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= (captureIrqFlag_r | captureEvent) & captureIrqEnable_r;
    end
  end

  // Read data registered in the setup cycle; unmapped reads give zero and pslverr
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= `ICU_WORD_ZERO;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= `ICU_WORD_ZERO;
      pslverr <= 1'b0;
      if (readAccess) begin
        unique case (paddr)
          `ICU_ADDR_CTRL: prdata <= {28'h0000000, captureModeField_r};
          `ICU_ADDR_CAPLO: prdata <= {24'h000000, captureValue_r[7:0]};
          `ICU_ADDR_CAPHI: prdata <= {24'h000000, captureValue_r[15:8]};
          `ICU_ADDR_STAT: prdata <= {31'h00000000, captureIrqFlag_r};
          `ICU_ADDR_MASK: prdata <= {31'h00000000, captureIrqEnable_r};
          `ICU_ADDR_TSEL: prdata <= {31'h00000000, thirdTimerControl_r};
          `ICU_ADDR_PIN: prdata <= {29'h00000000, pinSync, pinDirectionBit_r, pinLatch_r};
          default: pslverr <= 1'b1;
        endcase
      end else begin
        unique case (paddr)
          `ICU_ADDR_CTRL, `ICU_ADDR_STAT, `ICU_ADDR_MASK, `ICU_ADDR_TSEL, `ICU_ADDR_PIN: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Capture path
  a_capture_value: assert property (@(posedge clock) disable iff (srst)
    captureEvent |=> captureValue_r == $past(selCount))
    else $error("capture value wrong");
  a_value_hold: assert property (@(posedge clock) disable iff (srst)
    !captureEvent |=> $stable(captureValue_r))
    else $error("capture value changed without event");
  a_timer_sel: assert property (@(posedge clock) disable iff (srst)
    captureEvent && thirdTimerControl_r |=> captureValue_r == $past(thirdTimerCount))
    else $error("wrong timer captured");
  a_timer_first: assert property (@(posedge clock) disable iff (srst)
    captureEvent && !thirdTimerControl_r |=> captureValue_r == $past(firstTimerCount))
    else $error("first timer not captured");
  a_no_async: assert property (@(posedge clock) disable iff (srst)
    selAsync |-> !captureEvent)
    else $error("capture in async mode");
  a_off_idle: assert property (@(posedge clock) disable iff (srst)
    !isCaptureMode(captureModeField_r) |-> !captureEvent)
    else $error("capture while off");
  a_rise_mode: assert property (@(posedge clock) disable iff (srst)
    captureModeField_r == `ICU_MODE_RISE && !selAsync && $rose(pinSync) |-> captureEvent)
    else $error("rising edge missed");
  a_rise_only: assert property (@(posedge clock) disable iff (srst)
    captureModeField_r == `ICU_MODE_RISE && captureEvent |-> $rose(pinSync))
    else $error("rising capture off edge");
  a_fall_mode: assert property (@(posedge clock) disable iff (srst)
    captureModeField_r == `ICU_MODE_FALL && captureEvent |-> $fell(pinSync))
    else $error("falling capture off edge");
  a_fall_any: assert property (@(posedge clock) disable iff (srst)
    captureModeField_r == `ICU_MODE_FALL && !selAsync && $fell(pinSync) |-> captureEvent)
    else $error("falling edge missed");
  a_sync_delay: assert property (@(posedge clock) disable iff (srst)
    $rose(pinSync) |-> $past(captureInputPinIn, 2))
    else $error("pin edge seen out of time");

  // Flag and interrupt
  a_flag_sets: assert property (@(posedge clock) disable iff (srst)
    captureEvent |=> captureIrqFlag_r)
    else $error("flag not set");
  a_flag_sticky: assert property (@(posedge clock) disable iff (srst)
    captureIrqFlag_r && !(writeAccess && paddr == `ICU_ADDR_STAT) |=> captureIrqFlag_r)
    else $error("flag cleared by hardware");
  a_flag_clear: assert property (@(posedge clock) disable iff (srst)
    captureIrqFlag_r && !captureEvent && writeAccess && hitAddr(paddr, `ICU_ADDR_STAT) && pwdata[0]
      |=> !captureIrqFlag_r)
    else $error("flag not cleared by software");
  a_irq_level: assert property (@(posedge clock) disable iff (srst)
    captureIrqFlag_r && captureIrqEnable_r |=> irq)
    else $error("irq low with enabled flag");
  a_irq_event: assert property (@(posedge clock) disable iff (srst)
    captureEvent && captureIrqEnable_r |=> irq)
    else $error("irq late after capture");
  a_irq_masked: assert property (@(posedge clock) disable iff (srst)
    !captureIrqEnable_r |=> !irq)
    else $error("irq high while masked");

  // Prescaler
  a_ps_clear: assert property (@(posedge clock) disable iff (srst)
    !isCaptureMode(captureModeField_r) |=> psCount_r == `ICU_PS_ZERO)
    else $error("prescaler kept");
  a_ps_hold: assert property (@(posedge clock) disable iff (srst)
    isDivMode(captureModeField_r) && !(rawRise && !selAsync) |=> psCount_r == $past(psCount_r))
    else $error("prescaler count lost");
  a_ps_step: assert property (@(posedge clock) disable iff (srst)
    isDivMode(captureModeField_r) && rawRise && !selAsync && !psHit |=> psCount_r == $past(psCount_r) + 4'h1)
    else $error("prescaler did not count");
  a_div_wrap: assert property (@(posedge clock) disable iff (srst)
    isDivMode(captureModeField_r) && captureEvent |=> psCount_r == `ICU_PS_ZERO)
    else $error("prescaler not restarted");
  a_div_rise: assert property (@(posedge clock) disable iff (srst)
    isDivMode(captureModeField_r) && captureEvent |-> $rose(pinSync) && psHit)
    else $error("divided capture off ratio");
  // A count carried over from the sixteen setting may legally sit above three
  a_div4_count: assert property (@(posedge clock) disable iff (srst)
    captureModeField_r == `ICU_MODE_RISE4 && psCount_r <= `ICU_DIV4_LAST |=>
      captureModeField_r != `ICU_MODE_RISE4 || psCount_r <= `ICU_DIV4_LAST)
    else $error("div4 overrun");
  a_div16_hit: assert property (@(posedge clock) disable iff (srst)
    captureModeField_r == `ICU_MODE_RISE16 && captureEvent |-> psCount_r == `ICU_DIV16_LAST)
    else $error("div16 capture early");

  // Pin buffer
  a_pin_drive: assert property (@(posedge clock) disable iff (srst)
    !pinDirectionBit_r |=> !captureInputPinOe_n && captureInputPinOut == $past(pinLatch_r))
    else $error("pin not driven from latch");
  a_pin_input: assert property (@(posedge clock) disable iff (srst)
    pinDirectionBit_r |=> captureInputPinOe_n)
    else $error("pin driven while input");

  c_rise_cap: cover property (@(posedge clock) disable iff (srst)
    captureModeField_r == `ICU_MODE_RISE && captureEvent);
  c_fall_cap: cover property (@(posedge clock) disable iff (srst)
    captureModeField_r == `ICU_MODE_FALL && captureEvent);
  c_div16_cap: cover property (@(posedge clock) disable iff (srst)
    captureModeField_r == `ICU_MODE_RISE16 && captureEvent);
  c_overwrite: cover property (@(posedge clock) disable iff (srst)
    captureEvent ##[1:50] captureEvent);
  c_irq: cover property (@(posedge clock) disable iff (srst) $rose(irq));
endmodule
`default_nettype wire

// ### sim/icu_pin_source.sv
// Signal source model that drives the capture pin from outside
`timescale 1ns/1ps
`default_nettype none
module icu_pin_source (
  input wire logic srcDrive,
  input wire logic srcLevel,
  input wire logic devOut,
  input wire logic devOe_n,
  output logic pinLevel
);
  // Source drives only while the device leaves the pin as an input; a released pin floats to the pull-up
  always_comb begin
    if (!devOe_n) begin
      pinLevel = devOut;
    end else begin
      pinLevel = srcDrive ? srcLevel : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### sim/input_capture_unit_tb.sv
// Self-checking testbench for the input capture unit
`timescale 1ns/1ps
`default_nettype none
`include "icu_defs.svh"
module input_capture_unit_tb;
  import icu_pkg::*;
  logic clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, pinOut, pinOe_n, irq, pinIn, lastErr;
  logic srcDrive = 1'b1, srcLevel = 1'b0, async1 = 1'b0, async3 = 1'b0;
  icu_count_t t1 = 16'h1234, t3 = 16'h5678;
  int mismatches = 0, checkCount = 0;
  input_capture_unit i_input_capture_unit (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .captureInputPinIn(pinIn), .captureInputPinOut(pinOut), .captureInputPinOe_n(pinOe_n),
    .firstTimerCount(t1), .thirdTimerCount(t3), .firstTimerAsync(async1), .thirdTimerAsync(async3), .irq(irq));
  icu_pin_source i_icu_pin_source (.srcDrive(srcDrive), .srcLevel(srcLevel), .devOut(pinOut),
    .devOe_n(pinOe_n), .pinLevel(pinIn));
  initial begin
    forever #12.5 clock = ~clock;
  end
  task results();
    $display("Checks %0d, mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high
  task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (pready === 1'b1) begin
        break;
      end
    end
    if (n == 20) begin
      mismatches++;
      results();
    end
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdChk(input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // Rising then falling pin edges, each level held past the synchroniser delay
  task pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      srcLevel <= 1'b1;
      repeat (6) @(posedge clock);
      srcLevel <= 1'b0;
      repeat (6) @(posedge clock);
    end
  endtask
  task setMode(input logic [3:0] m);
    apb(1'b1, `ICU_ADDR_CTRL, {28'h0000000, m});
    apb(1'b1, `ICU_ADDR_STAT, 32'h0000_0001);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    rdChk(`ICU_ADDR_CTRL, 32'h0000_0000);
    rdChk(`ICU_ADDR_STAT, 32'h0000_0000);
    rdChk(`ICU_ADDR_PIN, 32'h0000_0002);
    rdChk(12'h01C, 32'h0000_0000);
    chk({31'h0, lastErr}, 32'h0000_0001);
    setMode(`ICU_MODE_RISE);
    pulses(1);
    rdChk(`ICU_ADDR_CAPLO, 32'h0000_0034);
    rdChk(`ICU_ADDR_CAPHI, 32'h0000_0012);
    rdChk(`ICU_ADDR_STAT, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `ICU_ADDR_MASK, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `ICU_ADDR_STAT, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `ICU_ADDR_TSEL, 32'h0000_0001);
    pulses(1);
    t3 <= 16'h9ABC;
    pulses(1);
    rdChk(`ICU_ADDR_CAPLO, 32'h0000_00BC);
    rdChk(`ICU_ADDR_CAPHI, 32'h0000_009A);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `ICU_ADDR_MASK, 32'h0000_0000);
    setMode(`ICU_MODE_FALL);
    t3 <= 16'h0F0F;
    srcLevel <= 1'b1;
    repeat (8) @(posedge clock);
    rdChk(`ICU_ADDR_STAT, 32'h0000_0000);
    srcLevel <= 1'b0;
    repeat (8) @(posedge clock);
    rdChk(`ICU_ADDR_STAT, 32'h0000_0001);
    rdChk(`ICU_ADDR_CAPLO, 32'h0000_000F);
    for (int i = 0; i < 2; i++) begin
      setMode(`ICU_MODE_OFF);
      setMode(i == 0 ? `ICU_MODE_RISE4 : `ICU_MODE_RISE16);
      pulses(i == 0 ? 3 : 15);
      rdChk(`ICU_ADDR_STAT, 32'h0000_0000);
      pulses(1);
      rdChk(`ICU_ADDR_STAT, 32'h0000_0001);
    end
    setMode(`ICU_MODE_RISE4);
    pulses(2);
    setMode(`ICU_MODE_OFF);
    setMode(`ICU_MODE_RISE4);
    pulses(3);
    rdChk(`ICU_ADDR_STAT, 32'h0000_0000);
    setMode(`ICU_MODE_RISE16);
    pulses(12);
    rdChk(`ICU_ADDR_STAT, 32'h0000_0000);
    pulses(1);
    rdChk(`ICU_ADDR_STAT, 32'h0000_0001);
    setMode(`ICU_MODE_RISE);
    async3 <= 1'b1;
    pulses(1);
    rdChk(`ICU_ADDR_STAT, 32'h0000_0000);
    async3 <= 1'b0;
    setMode(`ICU_MODE_OFF);
    apb(1'b1, `ICU_ADDR_PIN, 32'h0000_0000);
    srcDrive <= 1'b0;
    setMode(`ICU_MODE_RISE);
    apb(1'b1, `ICU_ADDR_PIN, 32'h0000_0001);
    repeat (8) @(posedge clock);
    rdChk(`ICU_ADDR_STAT, 32'h0000_0001);
    rdChk(`ICU_ADDR_PIN, 32'h0000_0005);
    results();
  end
endmodule
`default_nettype wire
